// ===== rtl/good_consts.svh
`ifndef GOOD_CONSTS_SVH
`define GOOD_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_LEVELS    8'h16
`define OFS_CONTROL   8'h17
`define OFS_SELECT_A  8'h18
`define OFS_FAULT_A   8'h19
`define OFS_SELECT_B  8'h1A
`define OFS_FAULT_B   8'h1B

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LEVELS    8'h00
`define RST_CONTROL   8'h02
`define RST_SELECT    8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_MODE_B    7
`define CTL_GATE_B    6
`define CTL_POL_B     4
`define CTL_MODE_A    3
`define CTL_GATE_A    2
`define CTL_DRIVE_A   1
`define CTL_POL_A     0
`define SEL_HOLDOFF   7
`define SRC_THERMAL   6
`define SRC_COUNT     7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HOLDOFF_MS    11
`define CLK_KHZ       40000
`endif

// ===== rtl/good_pkg.sv
package good_pkg;

    typedef struct packed {
        logic [1:0] boostLimitField;
        logic [1:0] boostThresholdField;
        logic [1:0] stepDownBLimitField;
        logic [1:0] stepDownALimitField;
    } levels_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrEn;
        logic       rdEn;
    } reg_req_type;

    typedef struct packed {
        logic thermalOk;
        logic analogSupplyOk;
        logic extMonitorBOk;
        logic extMonitorAOk;
        logic boostOk;
        logic stepDownBOk;
        logic stepDownAOk;
    } source_type;

endpackage

// ===== rtl/input_sync.sv
`timescale 1ns/100ps
module input_sync #(
    parameter int unsigned WIDTH = 7
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= d;
            stage2_q <= stage1_q;
        end
    end

    assign q = stage2_q;

endmodule

// ===== rtl/rise_holdoff.sv
`timescale 1ns/100ps
module rise_holdoff #(
    parameter int unsigned CYCLES = 440000
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic enable,
    input  wire logic rawValid,
    output logic      heldValid
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] count_q;
    logic          held_q;

    // ----------------------------------------------------------------
    // Rise delay, immediate fall
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            held_q  <= 1'b0;
            count_q <= '0;
        end else if (!rawValid) begin
            held_q  <= 1'b0;
            count_q <= '0;
        end else if (!enable) begin
            held_q  <= 1'b1;
        end else if (!held_q) begin
            if (count_q == LAST) begin
                held_q <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign heldValid = held_q;

    a_holdoff_wait:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(held_q) && $past(enable)
        |-> $past(count_q) == LAST)
    else $error("valid rose before the holdoff elapsed");

    a_holdoff_none:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        rst_b && rawValid && !enable |=> held_q)
    else $error("valid rise was delayed with holdoff off");

endmodule

// ===== rtl/power_good_output_logic.sv
`timescale 1ns/100ps
`include "good_consts.svh"
module power_good_output_logic #(
    parameter int unsigned HOLDOFF_CYCLES = `HOLDOFF_MS * `CLK_KHZ
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire good_pkg::reg_req_type regReq,
    output logic      [7:0]           regRdData,
    input  wire good_pkg::levels_type otpLevels,
    input  wire logic [7:0]           otpControl,
    input  wire logic [7:0]           otpSelectA,
    input  wire logic [7:0]           otpSelectB,
    input  wire good_pkg::source_type srcValidRaw,
    output good_pkg::levels_type      levels,
    output logic                      firstGoodOutput,
    output logic                      firstGoodOutputOe,
    output logic                      secondGoodOutput
);
    import good_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    levels_type                 levels_q;
    logic [7:0]                 control_q;
    logic [1:0][7:0]            select_q;
    logic [1:0][6:0]            fault_q;
    logic [1:0][6:0]            fault_d;
    logic                       otpLoaded_q;
    logic [7:0]                 regRdData_q;
    logic                       firstGoodOutput_q;
    logic                       firstGoodOutputOe_q;
    logic                       secondGoodOutput_q;

    logic [6:0]                 srcValid;
    logic [1:0][6:0]            effMask;
    logic [1:0][6:0]            failing;
    logic [1:0][6:0]            clrMask;
    logic [1:0]                 liveValid;
    logic [1:0]                 rawValid;
    logic [1:0]                 heldValid;
    logic [1:0]                 modeBit;
    logic [1:0]                 gateBit;
    logic [1:0]                 polBit;
    logic [1:0]                 holdEn;
    logic                       driveOpen;
    logic                       levelFirst;
    logic                       wrLevels;
    logic                       wrControl;
    logic [1:0]                 wrSelect;
    logic [1:0]                 wrFault;

    // ----------------------------------------------------------------
    // Source synchroniser
    // ----------------------------------------------------------------
    input_sync #(
        .WIDTH    (`SRC_COUNT)
    ) u_src_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .d        (srcValidRaw),
        .q        (srcValid)
    );

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    always_comb begin
        wrLevels    = regReq.wrEn && (regReq.addr == `OFS_LEVELS);
        wrControl   = regReq.wrEn && (regReq.addr == `OFS_CONTROL);
        wrSelect[0] = regReq.wrEn && (regReq.addr == `OFS_SELECT_A);
        wrSelect[1] = regReq.wrEn && (regReq.addr == `OFS_SELECT_B);
        wrFault[0]  = regReq.wrEn && (regReq.addr == `OFS_FAULT_A);
        wrFault[1]  = regReq.wrEn && (regReq.addr == `OFS_FAULT_B);
    end

    // ----------------------------------------------------------------
    // Control field decode
    // ----------------------------------------------------------------
    always_comb begin
        modeBit   = {control_q[`CTL_MODE_B], control_q[`CTL_MODE_A]};
        gateBit   = {control_q[`CTL_GATE_B], control_q[`CTL_GATE_A]};
        polBit    = {control_q[`CTL_POL_B], control_q[`CTL_POL_A]};
        holdEn    = {select_q[1][`SEL_HOLDOFF], select_q[0][`SEL_HOLDOFF]};
        driveOpen = control_q[`CTL_DRIVE_A];
    end

    // ----------------------------------------------------------------
    // OTP load after reset
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            otpLoaded_q <= 1'b0;
        end else begin
            otpLoaded_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            levels_q  <= levels_type'(`RST_LEVELS);
            control_q <= `RST_CONTROL;
            select_q  <= {`RST_SELECT, `RST_SELECT};
        end else if (!otpLoaded_q) begin
            levels_q  <= otpLevels;
            control_q <= otpControl;
            select_q  <= {otpSelectB, otpSelectA};
        end else begin
            if (wrLevels) begin
                levels_q <= levels_type'(regReq.wrData);
            end
            if (wrControl) begin
                control_q <= regReq.wrData;
            end
            if (wrSelect[0]) begin
                select_q[0] <= regReq.wrData;
            end
            if (wrSelect[1]) begin
                select_q[1] <= regReq.wrData;
            end
        end
    end

    assign levels = levels_q;

    // ----------------------------------------------------------------
    // Source combining and fault latching
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // Mode one drops the thermal warning from the sources
            effMask[i] = select_q[i][6:0]
                & ~{modeBit[i], 6'h00};
            failing[i] = effMask[i] & ~srcValid;
            liveValid[i] = &(srcValid | ~effMask[i]);
            clrMask[i] = wrFault[i] && otpLoaded_q
                ? (regReq.wrData[6:0] & srcValid) : 7'h00;
            // Set wins over a clear in the same cycle
            fault_d[i] = (fault_q[i] & ~clrMask[i]) | failing[i];
            rawValid[i] = gateBit[i] ? ~|fault_d[i]
                : liveValid[i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_q <= '0;
        end else begin
            fault_q <= fault_d;
        end
    end

    // ----------------------------------------------------------------
    // Rise holdoff per output
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < 2; gi++) begin : g_hold
        rise_holdoff #(
            .CYCLES    (HOLDOFF_CYCLES)
        ) u_hold (
            .core_clk  (core_clk),
            .rst_b     (rst_b),
            .enable    (holdEn[gi]),
            .rawValid  (rawValid[gi]),
            .heldValid (heldValid[gi])
        );
    end

    // ----------------------------------------------------------------
    // Output pins
    // ----------------------------------------------------------------
    assign levelFirst = heldValid[0] ^ polBit[0];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            firstGoodOutput_q   <= 1'b0;
            firstGoodOutputOe_q <= 1'b0;
        end else if (driveOpen) begin
            firstGoodOutput_q   <= 1'b0;
            firstGoodOutputOe_q <= ~levelFirst;
        end else begin
            firstGoodOutput_q   <= levelFirst;
            firstGoodOutputOe_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            secondGoodOutput_q <= 1'b0;
        end else begin
            secondGoodOutput_q <= heldValid[1] ^ polBit[1];
        end
    end

    assign firstGoodOutput   = firstGoodOutput_q;
    assign firstGoodOutputOe = firstGoodOutputOe_q;
    assign secondGoodOutput  = secondGoodOutput_q;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_q <= 8'h00;
        end else if (regReq.rdEn) begin
            case (regReq.addr)
                `OFS_LEVELS: begin
                    regRdData_q <= levels_q;
                end
                `OFS_CONTROL: begin
                    regRdData_q <= control_q;
                end
                `OFS_SELECT_A: begin
                    regRdData_q <= select_q[0];
                end
                `OFS_FAULT_A: begin
                    regRdData_q <= {1'b0, fault_q[0]};
                end
                `OFS_SELECT_B: begin
                    regRdData_q <= select_q[1];
                end
                `OFS_FAULT_B: begin
                    regRdData_q <= {1'b0, fault_q[1]};
                end
                default: begin
                    regRdData_q <= 8'h00;
                end
            endcase
        end
    end

    assign regRdData = regRdData_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_control_reset:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !otpLoaded_q |-> control_q == `RST_CONTROL)
    else $error("control register not at reset value before load");

    a_otp_load:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(otpLoaded_q) |-> levels_q == $past(otpLevels)
        && control_q == $past(otpControl)
        && select_q[0] == $past(otpSelectA)
        && select_q[1] == $past(otpSelectB))
    else $error("OTP defaults not loaded after reset");

    a_level_write:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        otpLoaded_q && wrLevels |=> levels == $past(regReq.wrData))
    else $error("window level write not taken");

    a_fault_set:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        failing[0][0] |=> fault_q[0][0])
    else $error("failing source did not latch its fault");

    a_fault_keep:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        fault_q[0][0] && !srcValid[0] |=> fault_q[0][0])
    else $error("fault cleared while source still invalid");

    a_fault_clear:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        otpLoaded_q && wrFault[0] && regReq.wrData[1] && srcValid[1]
        |=> !fault_q[0][1])
    else $error("fault not cleared by write one on valid source");

    a_live_drop:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !gateBit[0] && |failing[0] |=> !heldValid[0])
    else $error("first output stayed valid with a failing source");

    a_gate_first:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        gateBit[0] && |fault_d[0] |=> !heldValid[0])
    else $error("latched fault did not hold first output inactive");

    a_gate_second:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        gateBit[1] && |fault_d[1] |=> !heldValid[1])
    else $error("latched fault did not hold second output inactive");

    a_mode_thermal:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        modeBit[0] && !gateBit[0]
        && &(srcValid[5:0] | ~select_q[0][5:0]) |-> rawValid[0])
    else $error("mode one still reacts to the thermal warning");

    a_second_pol:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 secondGoodOutput == ($past(heldValid[1]) ^ $past(polBit[1])))
    else $error("second output polarity wrong");

    a_open_drain:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        rst_b && driveOpen |=> !firstGoodOutput
        && firstGoodOutputOe == !($past(heldValid[0]) ^ $past(polBit[0])))
    else $error("open-drain first output drives the wrong way");

    a_push_pull:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        rst_b && !driveOpen |=> firstGoodOutputOe
        && firstGoodOutput == ($past(heldValid[0]) ^ $past(polBit[0])))
    else $error("push-pull first output level wrong");

    a_second_drop:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !gateBit[1] && |failing[1] |=> !heldValid[1])
    else $error("second output stayed valid with a failing source");

    a_fault_sticky:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        !wrFault[0] && !wrFault[1]
        |=> (fault_q & $past(fault_q)) == $past(fault_q))
    else $error("fault bit cleared without a write");

    a_levels_hold:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        otpLoaded_q && !wrLevels |=> $stable(levels))
    else $error("window levels changed without a write");

    a_fault_read:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        regReq.rdEn && regReq.addr == `OFS_FAULT_A
        |=> regRdData == {1'b0, $past(fault_q[0])})
    else $error("first fault register read wrong");

    a_mode_second:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        modeBit[1] && !gateBit[1]
        && &(srcValid[5:0] | ~select_q[1][5:0]) |-> rawValid[1])
    else $error("second output mode one still reacts to thermal warning");

    a_gate_release:
    assert property (@(posedge core_clk) disable iff (!rst_b)
        gateBit[0] && !holdEn[0] && !(|fault_d[0]) |=> heldValid[0])
    else $error("first output not valid with no latched fault");

endmodule

// ===== verification/good_host_model.sv
`timescale 1ns/100ps
module good_host_model (
    input  wire logic firstGoodOutput,
    input  wire logic firstGoodOutputOe,
    input  wire logic secondGoodOutput,
    output logic      firstPin,
    output logic      secondPin
);
    // ------------------------------------------------------------
    // Pin levels seen by the host
    // ------------------------------------------------------------
    // Released open-drain line is held high by the board pull-up
    assign firstPin  = firstGoodOutputOe ? firstGoodOutput : 1'b1;
    assign secondPin = secondGoodOutput;
endmodule

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
    import good_pkg::*;
    localparam int unsigned HOLD = 8;
    localparam logic [7:0] OTP_LVL = 8'hE4;
    localparam logic [7:0] OTP_CTL = 8'h2A;
    localparam logic [7:0] OTP_SLA = 8'h5A;
    localparam logic [7:0] OTP_SLB = 8'h25;
    logic        core_clk;
    logic        rst_b;
    reg_req_type regReq;
    logic [7:0]  regRdData;
    source_type  srcValidRaw;
    levels_type  levels;
    logic        firstGoodOutput;
    logic        firstGoodOutputOe;
    logic        secondGoodOutput;
    logic        firstPin;
    logic        secondPin;
    int          errCount;
    int          checks;
    int          n;

    power_good_output_logic #(.HOLDOFF_CYCLES(HOLD)) dut (
        .core_clk          (core_clk),
        .rst_b             (rst_b),
        .regReq            (regReq),
        .regRdData         (regRdData),
        .otpLevels         (OTP_LVL),
        .otpControl        (OTP_CTL),
        .otpSelectA        (OTP_SLA),
        .otpSelectB        (OTP_SLB),
        .srcValidRaw       (srcValidRaw),
        .levels            (levels),
        .firstGoodOutput   (firstGoodOutput),
        .firstGoodOutputOe (firstGoodOutputOe),
        .secondGoodOutput  (secondGoodOutput)
    );

    good_host_model host (
        .firstGoodOutput   (firstGoodOutput),
        .firstGoodOutputOe (firstGoodOutputOe),
        .secondGoodOutput  (secondGoodOutput),
        .firstPin          (firstPin),
        .secondPin         (secondPin)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errCount++;
        printVerdict();
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= reg_req_type'{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        regReq <= '0;
        @(negedge core_clk);
    endtask

    task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regReq <= reg_req_type'{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        regReq <= '0;
        @(negedge core_clk);
        check(regRdData, exp);
    endtask

    task automatic setSrc(input logic [6:0] v);
        @(posedge core_clk);
        srcValidRaw <= v;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic printVerdict();
        $display("Checks %0d, mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        errCount = 0;
        checks = 0;
        rst_b = 1'b0;
        regReq = '0;
        srcValidRaw = 7'h7F;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        check(levels, 8'h00);
        check(firstGoodOutputOe, 1'b0);
        check(secondGoodOutput, 1'b0);
        check(regRdData, 8'h00);
        @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        rdck(8'h16, OTP_LVL);
        rdck(8'h17, OTP_CTL);
        rdck(8'h18, OTP_SLA);
        rdck(8'h1A, OTP_SLB);
        $display("Test reset done");

        for (int i = 0; i < 4; i++) begin
            wr(8'h16, 8'(i * 8'h55));
            check(levels, 8'(i * 8'h55));
            rdck(8'h16, 8'(i * 8'h55));
        end
        wr(8'h20, 8'h00);
        rdck(8'h20, 8'h00);
        rdck(8'h16, 8'hFF);
        $display("Test levels done");

        wr(8'h17, 8'h00);
        wr(8'h1A, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wr(8'h18, 8'(1 << k));
            setSrc(7'h7F ^ 7'(1 << k));
            check(firstPin, 1'b0);
            setSrc(7'h7F ^ 7'(1 << ((k + 1) % 7)));
            check(firstPin, 1'b1);
            check(firstGoodOutputOe, 1'b1);
        end
        wr(8'h18, 8'h7F);
        setSrc(7'h7B);
        check(firstPin, 1'b0);
        setSrc(7'h7F);
        check(firstPin, 1'b1);
        $display("Test sources done");

        wr(8'h17, 8'h11);
        wr(8'h18, 8'h01);
        wr(8'h1A, 8'h01);
        setSrc(7'h7F);
        check({firstPin, secondPin}, 2'b00);
        setSrc(7'h7E);
        check({firstPin, secondPin}, 2'b11);
        wr(8'h17, 8'h02);
        setSrc(7'h7F);
        check({firstGoodOutputOe, firstPin}, 2'b01);
        setSrc(7'h7E);
        check({firstGoodOutputOe, firstGoodOutput}, 2'b10);
        $display("Test pin type done");

        wr(8'h17, 8'h88);
        wr(8'h18, 8'h41);
        wr(8'h1A, 8'h40);
        setSrc(7'h3F);
        check({firstPin, secondPin}, 2'b11);
        wr(8'h17, 8'h00);
        setSrc(7'h3F);
        check({firstPin, secondPin}, 2'b00);
        $display("Test mode done");

        setSrc(7'h7F);
        wr(8'h19, 8'hFF);
        wr(8'h1B, 8'hFF);
        rdck(8'h19, 8'h00);
        rdck(8'h1B, 8'h00);
        wr(8'h17, 8'h44);
        wr(8'h18, 8'h01);
        wr(8'h1A, 8'h02);
        setSrc(7'h7E);
        check({firstPin, secondPin}, 2'b01);
        rdck(8'h19, 8'h01);
        wr(8'h19, 8'h01);
        rdck(8'h19, 8'h01);
        setSrc(7'h7F);
        check(firstPin, 1'b0);
        wr(8'h19, 8'h01);
        setSrc(7'h7F);
        rdck(8'h19, 8'h00);
        check(firstPin, 1'b1);
        setSrc(7'h7D);
        rdck(8'h1B, 8'h02);
        setSrc(7'h7F);
        check(secondPin, 1'b0);
        wr(8'h1B, 8'h02);
        setSrc(7'h7F);
        check(secondPin, 1'b1);
        $display("Test latched done");

        wr(8'h17, 8'h00);
        wr(8'h18, 8'h81);
        wr(8'h1A, 8'h81);
        setSrc(7'h7E);
        check({firstPin, secondPin}, 2'b00);
        @(posedge core_clk);
        srcValidRaw <= 7'h7F;
        n = 0;
        while (firstPin !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        check(n >= HOLD && n <= HOLD + 6, 1'b1);
        check(secondPin, 1'b1);
        $display("Test holdoff done");
        printVerdict();
    end
endmodule
